/* File: dv/ebw_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ebw_mem_model #(
  parameter int SLOW = 0
) (
  // clock
  input wire logic clock_in,
  // device bus pins
  input wire logic [22:0] ext_addr_in,
  input wire logic memory_strobe_n_in,
  input wire logic ext_data_oe_n_in,
  input wire logic [15:0] ext_data_drv_in,
  // resolved data wire
  output logic [15:0] ext_data_out
);
  logic [15:0] mem_q [16];
  logic [22:0] last_addr_q;
  logic [15:0] stale_q;
  int age_q;
  // known pattern so every read has a fixed answer
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 16'h1000 + 16'(i);
    end
    last_addr_q = '0;
    stale_q = '0;
    age_q = 0;
  end
  // write while the device drives under strobe; track access time
  always @(posedge clock_in) begin
    if (!memory_strobe_n_in && !ext_data_oe_n_in) begin
      mem_q[ext_addr_in[3:0]] <= ext_data_drv_in;
    end
    if (ext_addr_in != last_addr_q) begin
      age_q <= 0;
      stale_q <= ~ext_data_out;
    end else if (age_q < SLOW) begin
      age_q <= age_q + 1;
    end
    last_addr_q <= ext_addr_in;
  end
  // garbage until the access time has run out, so a slow memory is not kind
  assign ext_data_out = !ext_data_oe_n_in ? ext_data_drv_in :
    ((age_q >= SLOW) ? mem_q[ext_addr_in[3:0]] : stale_q);
endmodule
`default_nettype wire

/* File: dv/ext_bus_wait_bank_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ext_bus_wait_bank_control_tb;
  import ebw_pkg::*;
  // one access: register setup, request, expected strobe cycles and edges to done
  typedef struct {
    logic [15:0] bank_ctrl;
    logic [15:0] wait_cnt;
    logic [15:0] mult;
    logic write;
    logic [1:0] space;
    logic [22:0] addr;
    logic [15:0] data;
    int low;
    int total;
  } ebw_case_type;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [15:0] mmr_addr_in = 16'h0000;
  logic mmr_wr_in = 1'b0;
  logic mmr_rd_in = 1'b0;
  logic [15:0] mmr_wdata_in = 16'h0000;
  logic [15:0] mmr_rdata_out;
  logic acc_req_in = 1'b0;
  logic acc_write_in = 1'b0;
  logic [1:0] acc_space_in = 2'h0;
  logic [22:0] acc_addr_in = 23'h000000;
  logic [15:0] acc_wdata_in = 16'h0000;
  logic acc_done_out;
  logic [15:0] acc_rdata_out;
  logic [22:0] ext_addr_out;
  logic memory_strobe_n_out;
  logic [15:0] ext_data_in;
  logic [15:0] ext_data_out;
  logic ext_data_oe_n_out;
  logic bus_clock_output_out;
  logic [7:0] host_port_data_pins_in = 8'h5a;
  logic data_bus_keeper_enable_out;
  logic [15:0] data_keeper_level_out;
  logic host_bus_keeper_enable_out;
  logic [7:0] host_keeper_level_out;
  logic interrupt_ack_output_req_in = 1'b0;
  logic interrupt_ack_output_n_out;
  int n_fail = 0;
  int checks_done = 0;
  // edges counted from the one that raises the request; read data passes a
  // two-flop pin sync, so a read whose address changed under a gap gets one
  // wait, and rows 7 and 8 alias the same model word; the last row uses XPA
  ebw_case_type rows [13] = '{
    '{16'h0000, 16'h0000, 16'h0000, 1'b1, SPACE_PROG, 23'h000100, 16'h1234, 1, 2},
    '{16'h0000, 16'h0000, 16'h0000, 1'b0, SPACE_PROG, 23'h000100, 16'h1234, 1, 2},
    '{16'h0000, 16'h0008, 16'h0000, 1'b0, SPACE_PROG, 23'h008101, 16'h1001, 2, 4},
    '{16'h0000, 16'h0200, 16'h0000, 1'b0, SPACE_DATA, 23'h008102, 16'h1002, 2, 4},
    '{16'h0000, 16'h0000, 16'h0000, 1'b0, SPACE_DATA, 23'h008102, 16'h1002, 1, 2},
    '{16'h8000, 16'h0000, 16'h0000, 1'b0, SPACE_DATA, 23'h008102, 16'h1002, 1, 4},
    '{16'h0000, 16'h0600, 16'h0000, 1'b0, SPACE_DATA, 23'h008105, 16'h1005, 4, 5},
    '{16'h0000, 16'h0600, 16'h0001, 1'b0, SPACE_DATA, 23'h008107, 16'h1007, 7, 8},
    '{16'h0000, 16'h01c0, 16'h0000, 1'b0, SPACE_DATA, 23'h000007, 16'h1007, 1, 3},
    '{16'h0000, 16'h2000, 16'h0000, 1'b0, SPACE_IO, 23'h000008, 16'h1008, 3, 4},
    '{16'h0000, 16'h0001, 16'h0000, 1'b0, SPACE_PROG, 23'h000109, 16'h1009, 2, 4},
    '{16'h0000, 16'h0001, 16'h0000, 1'b0, SPACE_PROG, 23'h01010a, 16'h100a, 2, 4},
    '{16'h6000, 16'h8001, 16'h0000, 1'b0, SPACE_PROG, 23'h01810b, 16'h100b, 8, 0}
  };

  ebw_ctrl ebw_ctrl_i (
    .clock_in(clock_in), .rstn_in(rstn_in),
    .mmr_addr_in(mmr_addr_in), .mmr_wr_in(mmr_wr_in), .mmr_rd_in(mmr_rd_in),
    .mmr_wdata_in(mmr_wdata_in), .mmr_rdata_out(mmr_rdata_out),
    .acc_req_in(acc_req_in), .acc_write_in(acc_write_in), .acc_space_in(acc_space_in),
    .acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in), .acc_done_out(acc_done_out),
    .acc_rdata_out(acc_rdata_out), .ext_addr_out(ext_addr_out),
    .memory_strobe_n_out(memory_strobe_n_out), .ext_data_in(ext_data_in),
    .ext_data_out(ext_data_out), .ext_data_oe_n_out(ext_data_oe_n_out),
    .bus_clock_output_out(bus_clock_output_out),
    .host_port_data_pins_in(host_port_data_pins_in),
    .data_bus_keeper_enable_out(data_bus_keeper_enable_out),
    .data_keeper_level_out(data_keeper_level_out),
    .host_bus_keeper_enable_out(host_bus_keeper_enable_out),
    .host_keeper_level_out(host_keeper_level_out),
    .interrupt_ack_output_req_in(interrupt_ack_output_req_in), .interrupt_ack_output_n_out(interrupt_ack_output_n_out)
  );
  ebw_mem_model ebw_mem_model_i (
    .clock_in(clock_in), .ext_addr_in(ext_addr_out),
    .memory_strobe_n_in(memory_strobe_n_out), .ext_data_oe_n_in(ext_data_oe_n_out),
    .ext_data_drv_in(ext_data_out), .ext_data_out(ext_data_in)
  );

  // 40 MHz processor clock
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_word(input string name, input logic [22:0] exp, input logic [22:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic chk_count(input string name, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
    end
  endtask
  task automatic mmr_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_in);
    mmr_addr_in <= a;
    mmr_wdata_in <= d;
    mmr_wr_in <= 1'b1;
    @(posedge clock_in);
    mmr_wr_in <= 1'b0;
  endtask
  // read data stands only in the cycle after the read edge
  task automatic chk_reg(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock_in);
    mmr_addr_in <= a;
    mmr_rd_in <= 1'b1;
    @(posedge clock_in);
    mmr_rd_in <= 1'b0;
    #1;
    chk_word("register read", 23'(exp), 23'(mmr_rdata_out));
  endtask
  task automatic do_access(input ebw_case_type c);
    int n;
    int low;
    n = 0;
    low = 0;
    mmr_write(BANK_CTRL_ADDR, c.bank_ctrl);
    mmr_write(WAIT_COUNT_ADDR, c.wait_cnt);
    mmr_write(WAIT_MULT_ADDR, c.mult);
    @(posedge clock_in);
    acc_req_in <= 1'b1;
    acc_write_in <= c.write;
    acc_space_in <= c.space;
    acc_addr_in <= c.addr;
    acc_wdata_in <= c.data;
    while (n < 200 && acc_done_out !== 1'b1) begin
      @(posedge clock_in);
      #1;
      n++;
      if (memory_strobe_n_out === 1'b0) low++;
    end
    // dropped before the next edge, otherwise the request is taken twice
    acc_req_in <= 1'b0;
    if (acc_done_out !== 1'b1) begin
      n_fail++;
      results();
    end
    if (c.total > 0) chk_count("edges to done", c.total, n);
    chk_count("strobe low cycles", c.low, low);
    if (!c.write) chk_word("read data", 23'(c.data), 23'(acc_rdata_out));
    chk_word("address pins", c.addr, ext_addr_out);
  endtask
  task automatic pulse_ack(input logic exp);
    @(posedge clock_in);
    interrupt_ack_output_req_in <= 1'b1;
    @(posedge clock_in);
    interrupt_ack_output_req_in <= 1'b0;
    #1;
    chk_word("ack output", 23'(exp), 23'(interrupt_ack_output_n_out));
  endtask
  task automatic reset_checks();
    chk_reg(WAIT_COUNT_ADDR, 16'h7fff);
    chk_reg(BANK_CTRL_ADDR, 16'hf000);
    chk_reg(WAIT_MULT_ADDR, 16'h0000);
    chk_word("data keeper", 23'h0, 23'(data_bus_keeper_enable_out));
    chk_word("host keeper", 23'h0, 23'(host_bus_keeper_enable_out));
  endtask

  initial begin
    int rises;
    int highs;
    logic prev;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    // ordinary access cases
    for (int i = 0; i < 13; i++) begin
      do_access(rows[i]);
      $display("access case %0d done", i);
    end
    // bus clock ratio for every divide code
    for (int d = 0; d < 4; d++) begin
      mmr_write(BANK_CTRL_ADDR, {1'b0, 2'(d), 13'h0000});
      repeat (4) @(posedge clock_in);
      #1;
      rises = 0;
      highs = 0;
      for (int k = 0; k < 24; k++) begin
        prev = bus_clock_output_out;
        @(posedge clock_in);
        #1;
        if (bus_clock_output_out === 1'b1 && prev === 1'b0) rises++;
        if (bus_clock_output_out === 1'b1) highs++;
      end
      chk_count("bus clock rises", (d == 0) ? 0 : 24 / (d + 1), rises);
      if (d == 0) chk_count("bus clock high", 24, highs);
    end
    $display("bus clock test done");
    // masking, keepers and acknowledge suppression
    mmr_write(BANK_CTRL_ADDR, 16'hffff);
    chk_reg(BANK_CTRL_ADDR, 16'hf006);
    chk_word("data keeper", 23'h1, 23'(data_bus_keeper_enable_out));
    chk_word("host keeper", 23'h1, 23'(host_bus_keeper_enable_out));
    chk_word("host level", 23'h5a, 23'(host_keeper_level_out));
    chk_word("data level", 23'h100b, 23'(data_keeper_level_out));
    pulse_ack(1'b1);
    mmr_write(BANK_CTRL_ADDR, 16'h0000);
    pulse_ack(1'b0);
    mmr_write(WAIT_MULT_ADDR, 16'hffff);
    chk_reg(WAIT_MULT_ADDR, 16'h0001);
    mmr_write(16'h002a, 16'hffff);
    chk_reg(16'h002a, 16'h0000);
    $display("register test done");
    // reset in mid-run brings the register and keeper-enable defaults back
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    chk_word("strobe in reset", 23'h1, 23'(memory_strobe_n_out));
    @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    reset_checks();
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire

/* File: hw/ebw_clk_div.sv */
`timescale 1ns/10ps
`default_nettype none
module ebw_clk_div
  import ebw_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // divide field
  input wire logic [1:0] div_in,
  // bus clock and end-of-bus-cycle tick
  output logic bus_clock_out,
  output logic tick_out
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic last_w;
  logic high_w;

  // last phase of a bus cycle; ratio is div_in + 1 processor clocks
  assign last_w = (cnt_q >= div_in);
  assign cnt_d = last_w ? 2'h0 : cnt_q + 2'h1;
  // high during the first half; at ratio 1 the output stays high,
  // since a register cannot toggle at the processor clock rate
  assign high_w = (cnt_d <= (div_in >> 1)) || (div_in == 2'h0);

  // counter and registered outputs
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 2'h0;
      tick_out <= 1'b0;
      bus_clock_out <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      tick_out <= last_w;
      bus_clock_out <= high_w;
    end
  end

  // a tick with the field held at 3 for three clocks is followed by three idle clocks
  chk_tick_spacing: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $past(tick_out, 2) && $past(div_in, 2) == 2'h3 && $past(div_in) == 2'h3 &&
    div_in == 2'h3 |-> !$past(tick_out) && !tick_out ##1 !tick_out)
    else $error("bus tick spacing wrong for divide by 4");
  cov_div_one: cover property (@(posedge clock_in) disable iff (!rstn_in)
    div_in == 2'h0 && tick_out);
endmodule
`default_nettype wire

/* File: hw/ebw_ctrl.sv */
// Functional notes
// - multiplier bit doubles every wait count
// - multiplier at bit 0, address 2Bh
// - extra cycle when accesses cross 32K banks
// - consecutive off: gap only on bank, space or page change
// - consecutive on: start, read, trail cycles
// - bus clock is processor clock over field+1; held high at field 0
// - all external timing stretched by divider
// - divide field codes 0..3, resets to 11
// - ack-off bit 12 suppresses ack, resets 1
// - host keeper bit 2, reset off
// - data keeper bit 1, reset off
// - lower data wait field has no effect
// - bank control register at address 29h
// - wait counts reset 7FFFh, multiplier cleared
// - gap for bank, space, page changes
// - strobe high one bus cycle during gap
`timescale 1ns/10ps
`default_nettype none
module ebw_ctrl
  import ebw_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // memory-mapped register port from the core
  input wire logic [15:0] mmr_addr_in,
  input wire logic mmr_wr_in,
  input wire logic mmr_rd_in,
  input wire logic [15:0] mmr_wdata_in,
  output logic [15:0] mmr_rdata_out,
  // external access request from the core
  input wire logic acc_req_in,
  input wire logic acc_write_in,
  input wire logic [1:0] acc_space_in,
  input wire logic [22:0] acc_addr_in,
  input wire logic [15:0] acc_wdata_in,
  output logic acc_done_out,
  output logic [15:0] acc_rdata_out,
  // external memory bus pins
  output logic [22:0] ext_addr_out,
  output logic memory_strobe_n_out,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe_n_out,
  output logic bus_clock_output_out,
  // bus keepers
  input wire logic [7:0] host_port_data_pins_in,
  output logic data_bus_keeper_enable_out,
  output logic [15:0] data_keeper_level_out,
  output logic host_bus_keeper_enable_out,
  output logic [7:0] host_keeper_level_out,
  // interrupt acknowledge
  input wire logic interrupt_ack_output_req_in,
  output logic interrupt_ack_output_n_out
);
  // returns the three-bit wait field at a position of the count register
  function automatic logic [2:0] wait_field(input logic [15:0] reg_v, input int lsb);
    wait_field = reg_v[lsb +: 3];
  endfunction

  logic rst_s1_q;
  logic rstn_q;
  logic [15:0] wait_count_register_q;
  logic [15:0] wait_multiplier_control_q;
  logic [15:0] bank_switch_control_q;
  logic [15:0] data_s1_q;
  logic [15:0] data_s2_q;
  logic [7:0] host_s1_q;
  logic [7:0] host_s2_q;
  ebw_state_type state_q;
  ebw_state_type state_d;
  logic [3:0] wait_cnt_q;
  logic [3:0] wait_cnt_d;
  logic consecutive_bank_mode_rd_q;
  logic last_valid_q;
  logic last_read_q;
  logic last_prog_q;
  logic last_bank_q;
  logic [6:0] last_page_q;
  logic tick_w;
  logic bus_clock_w;
  logic wr_wait_w;
  logic wr_bank_w;
  logic wr_mult_w;
  logic [15:0] rd_mux_w;
  logic wait_multiplier_bit_w;
  logic consecutive_bank_mode_w;
  logic [1:0] bus_clock_divide_field_w;
  logic ack_output_disable_w;
  logic mem_space_w;
  logic is_prog_w;
  logic is_read_w;
  logic bank_change_w;
  logic gap_needed_w;
  logic [2:0] base_wait_w;
  logic [3:0] wait_total_w;
  logic take_w;
  logic finish_w;

  // reset release through two flops
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rstn_q <= rst_s1_q;
    end
  end

  // pin synchronisers for data bus and host-port data
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      data_s1_q <= 16'h0000;
      data_s2_q <= 16'h0000;
      host_s1_q <= 8'h00;
      host_s2_q <= 8'h00;
    end else begin
      data_s1_q <= ext_data_in;
      data_s2_q <= data_s1_q;
      host_s1_q <= host_port_data_pins_in;
      host_s2_q <= host_s1_q;
    end
  end

  // register decode
  assign wr_wait_w = mmr_wr_in && (mmr_addr_in == WAIT_COUNT_ADDR);
  assign wr_bank_w = mmr_wr_in && (mmr_addr_in == BANK_CTRL_ADDR);
  assign wr_mult_w = mmr_wr_in && (mmr_addr_in == WAIT_MULT_ADDR);
  assign rd_mux_w = (mmr_addr_in == WAIT_COUNT_ADDR) ? wait_count_register_q :
                    (mmr_addr_in == BANK_CTRL_ADDR) ? bank_switch_control_q :
                    (mmr_addr_in == WAIT_MULT_ADDR) ? wait_multiplier_control_q :
                    16'h0000;

  // control registers; reserved bits masked so they stay zero
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      wait_count_register_q <= WAIT_COUNT_RESET;
      wait_multiplier_control_q <= WAIT_MULT_RESET;
      bank_switch_control_q <= BANK_CTRL_RESET;
      mmr_rdata_out <= 16'h0000;
    end else begin
      if (wr_wait_w) begin
        wait_count_register_q <= mmr_wdata_in;
      end
      if (wr_mult_w) begin
        wait_multiplier_control_q <= mmr_wdata_in & WAIT_MULT_MASK;
      end
      if (wr_bank_w) begin
        bank_switch_control_q <= mmr_wdata_in & BANK_CTRL_MASK;
      end
      mmr_rdata_out <= mmr_rd_in ? rd_mux_w : 16'h0000;
    end
  end

  // named control bits
  assign wait_multiplier_bit_w = wait_multiplier_control_q[MULT_BIT];
  assign consecutive_bank_mode_w = bank_switch_control_q[CONSECUTIVE_BANK_MODE_BIT];
  assign bus_clock_divide_field_w = bank_switch_control_q[DIV_LSB +: 2];
  assign ack_output_disable_w = bank_switch_control_q[ACK_OFF_BIT];

  // bus clock divider; its tick paces every bus phase below
  ebw_clk_div u_div (
    .clock_in(clock_in),
    .rstn_in(rstn_q),
    .div_in(bus_clock_divide_field_w),
    .bus_clock_out(bus_clock_w),
    .tick_out(tick_w)
  );

  // wait field select; lower data space has no external memory, so its
  // field is never consulted and such accesses run with no waits
  always_comb begin
    base_wait_w = 3'h0;
    unique case (acc_space_in)
      SPACE_PROG: begin
        if (wait_count_register_q[XPA_BIT]) begin
          base_wait_w = acc_addr_in[XPA_RANGE_BIT] ?
                        wait_field(wait_count_register_q, PROG_HI_WAIT_LSB) :
                        wait_field(wait_count_register_q, PROG_LO_WAIT_LSB);
        end else begin
          base_wait_w = acc_addr_in[BANK_BIT] ?
                        wait_field(wait_count_register_q, PROG_HI_WAIT_LSB) :
                        wait_field(wait_count_register_q, PROG_LO_WAIT_LSB);
        end
      end
      SPACE_DATA: begin
        base_wait_w = acc_addr_in[BANK_BIT] ?
                      wait_field(wait_count_register_q, DATA_HI_WAIT_LSB) : 3'h0;
      end
      default: begin
        base_wait_w = wait_field(wait_count_register_q, IO_WAIT_LSB);
      end
    endcase
  end
  assign wait_total_w = wait_multiplier_bit_w ? {base_wait_w, 1'b0} :
                        {1'b0, base_wait_w};

  // bank-switch detection against the last program/data access
  assign is_prog_w = (acc_space_in == SPACE_PROG);
  assign mem_space_w = is_prog_w || (acc_space_in == SPACE_DATA);
  assign is_read_w = !acc_write_in;
  assign bank_change_w = last_valid_q && last_read_q &&
                         ((last_prog_q != is_prog_w) ||
                          (last_bank_q != acc_addr_in[BANK_BIT]) ||
                          (is_prog_w && last_page_q != acc_addr_in[22:PAGE_LSB]));
  assign gap_needed_w = mem_space_w && is_read_w && bank_change_w;
  assign take_w = (state_q == ST_IDLE) && acc_req_in && tick_w;

  // sequencer: every phase lasts whole bus cycles, so the divider
  // stretches all external timing together with the waits
  always_comb begin
    state_d = state_q;
    wait_cnt_d = wait_cnt_q;
    finish_w = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (take_w) begin
          wait_cnt_d = wait_total_w;
          if (mem_space_w && is_read_w && consecutive_bank_mode_w) begin
            state_d = ST_START;
          end else if (gap_needed_w) begin
            state_d = ST_GAP;
          end else begin
            state_d = ST_STROBE;
          end
        end
      end
      ST_GAP, ST_START: begin
        if (tick_w) begin
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tick_w) begin
          if (wait_cnt_q != 4'h0) begin
            wait_cnt_d = wait_cnt_q - 4'h1;
          end else if (consecutive_bank_mode_rd_q) begin
            state_d = ST_TRAIL;
          end else begin
            state_d = ST_IDLE;
            finish_w = 1'b1;
          end
        end
      end
      ST_TRAIL: begin
        if (tick_w) begin
          state_d = ST_IDLE;
          finish_w = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer state and last-access record
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      state_q <= ST_IDLE;
      wait_cnt_q <= 4'h0;
      consecutive_bank_mode_rd_q <= 1'b0;
      last_valid_q <= 1'b0;
      last_read_q <= 1'b0;
      last_prog_q <= 1'b0;
      last_bank_q <= 1'b0;
      last_page_q <= 7'h00;
    end else begin
      state_q <= state_d;
      wait_cnt_q <= wait_cnt_d;
      if (take_w) begin
        consecutive_bank_mode_rd_q <= mem_space_w && is_read_w && consecutive_bank_mode_w;
      end
      if (take_w && mem_space_w) begin
        last_valid_q <= 1'b1;
        last_read_q <= is_read_w;
        last_prog_q <= is_prog_w;
        last_bank_q <= acc_addr_in[BANK_BIT];
        last_page_q <= acc_addr_in[22:PAGE_LSB];
      end
    end
  end

  // pin drivers; strobe stays high through gap, start and trail
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      ext_addr_out <= 23'h000000;
      memory_strobe_n_out <= 1'b1;
      ext_data_out <= 16'h0000;
      ext_data_oe_n_out <= 1'b1;
      acc_done_out <= 1'b0;
      acc_rdata_out <= 16'h0000;
      bus_clock_output_out <= 1'b1;
    end else begin
      if (take_w) begin
        ext_addr_out <= acc_addr_in;
        ext_data_out <= acc_wdata_in;
      end
      memory_strobe_n_out <= (state_d != ST_STROBE);
      ext_data_oe_n_out <= !((state_d == ST_STROBE) && acc_write_in);
      acc_done_out <= finish_w;
      if (state_q == ST_STROBE && state_d != ST_STROBE) begin
        acc_rdata_out <= data_s2_q;
      end
      bus_clock_output_out <= bus_clock_w;
    end
  end

  // keepers: enables plus the last sampled level to hold on the pins
  always_ff @(posedge clock_in or negedge rstn_q) begin
    if (!rstn_q) begin
      data_bus_keeper_enable_out <= 1'b0;
      host_bus_keeper_enable_out <= 1'b0;
      data_keeper_level_out <= 16'h0000;
      host_keeper_level_out <= 8'h00;
      interrupt_ack_output_n_out <= 1'b1;
    end else begin
      data_bus_keeper_enable_out <= bank_switch_control_q[DATA_KEEP_BIT];
      host_bus_keeper_enable_out <= bank_switch_control_q[HOST_KEEP_BIT];
      data_keeper_level_out <= ext_data_oe_n_out ? data_s2_q : ext_data_out;
      host_keeper_level_out <= host_s2_q;
      interrupt_ack_output_n_out <= !(interrupt_ack_output_req_in && !ack_output_disable_w);
    end
  end

  chk_mult_double: assert property (@(posedge clock_in) disable iff (!rstn_q)
    take_w && wait_multiplier_bit_w |=> wait_cnt_q == {$past(base_wait_w), 1'b0})
    else $error("wait count not doubled");
  chk_mult_reserved: assert property (@(posedge clock_in) disable iff (!rstn_q)
    mmr_rd_in && mmr_addr_in == WAIT_MULT_ADDR |=> mmr_rdata_out[15:1] == 15'h0000)
    else $error("reserved multiplier bits not zero");
  chk_bank_gap: assert property (@(posedge clock_in) disable iff (!rstn_q)
    take_w && gap_needed_w && !consecutive_bank_mode_w |=> state_q == ST_GAP)
    else $error("bank gap missing");
  chk_no_gap: assert property (@(posedge clock_in) disable iff (!rstn_q)
    take_w && !gap_needed_w && !consecutive_bank_mode_w |=> state_q == ST_STROBE)
    else $error("unexpected gap");
  chk_consecutive_bank_mode_start: assert property (@(posedge clock_in) disable iff (!rstn_q)
    take_w && is_read_w && mem_space_w && consecutive_bank_mode_w
    |=> state_q == ST_START)
    else $error("starting cycle missing");
  // done is registered on the same edge that returns the sequencer to idle
  chk_trail_end: assert property (@(posedge clock_in) disable iff (!rstn_q)
    state_q == ST_TRAIL && tick_w |=> state_q == ST_IDLE && acc_done_out)
    else $error("trailing cycle did not end access");
  // the new address is already on the pins while the strobe rests high
  chk_gap_strobe: assert property (@(posedge clock_in) disable iff (!rstn_q)
    state_q == ST_GAP |-> memory_strobe_n_out && ext_addr_out == $past(acc_addr_in))
    else $error("strobe active or address stale in gap");
  chk_div_write: assert property (@(posedge clock_in) disable iff (!rstn_q)
    wr_bank_w |=> bus_clock_divide_field_w == $past(mmr_wdata_in[14:13]))
    else $error("divide field write lost");
  chk_ack_suppress: assert property (@(posedge clock_in) disable iff (!rstn_q)
    interrupt_ack_output_req_in && ack_output_disable_w |=> interrupt_ack_output_n_out)
    else $error("ack not suppressed");
  chk_keeper_bits: assert property (@(posedge clock_in) disable iff (!rstn_q)
    wr_bank_w ##2 1'b1 |-> data_bus_keeper_enable_out == $past(mmr_wdata_in[1], 2) &&
    host_bus_keeper_enable_out == $past(mmr_wdata_in[2], 2))
    else $error("keeper enables wrong");
  cov_gap_read: cover property (@(posedge clock_in) disable iff (!rstn_q)
    state_q == ST_GAP ##[1:8] state_q == ST_STROBE);
  cov_consecutive_bank_mode_read: cover property (@(posedge clock_in) disable iff (!rstn_q)
    state_q == ST_TRAIL ##[1:8] acc_done_out);
  cov_doubled_wait: cover property (@(posedge clock_in) disable iff (!rstn_q)
    take_w && wait_multiplier_bit_w && base_wait_w != 3'h0);
endmodule
`default_nettype wire

/* File: hw/ebw_pkg.sv */
package ebw_pkg;
  // memory-mapped register word addresses in data space
  localparam logic [15:0] WAIT_COUNT_ADDR = 16'h0028;
  localparam logic [15:0] BANK_CTRL_ADDR = 16'h0029;
  localparam logic [15:0] WAIT_MULT_ADDR = 16'h002b;
  // reset values
  localparam logic [15:0] WAIT_COUNT_RESET = 16'h7fff;
  localparam logic [15:0] WAIT_MULT_RESET = 16'h0000;
  localparam logic [15:0] BANK_CTRL_RESET = 16'hf000;
  // writable bits; everything else reads zero
  localparam logic [15:0] WAIT_MULT_MASK = 16'h0001;
  localparam logic [15:0] BANK_CTRL_MASK = 16'hf006;
  // field positions
  localparam int MULT_BIT = 0;
  localparam int CONSECUTIVE_BANK_MODE_BIT = 15;
  localparam int DIV_LSB = 13;
  localparam int ACK_OFF_BIT = 12;
  localparam int HOST_KEEP_BIT = 2;
  localparam int DATA_KEEP_BIT = 1;
  localparam int XPA_BIT = 15;
  localparam int IO_WAIT_LSB = 12;
  localparam int DATA_HI_WAIT_LSB = 9;
  localparam int PROG_HI_WAIT_LSB = 3;
  localparam int PROG_LO_WAIT_LSB = 0;
  // bank boundary: 32K words, so address bit 15 picks the bank
  localparam int BANK_BIT = 15;
  localparam int PAGE_LSB = 16;
  localparam int XPA_RANGE_BIT = 22;
  // bus clock divide field reset code (divide by 4)
  localparam logic [1:0] DIV_RESET = 2'h3;

  // access space codes
  typedef enum logic [1:0] {
    SPACE_PROG = 2'h0,
    SPACE_DATA = 2'h1,
    SPACE_IO = 2'h2
  } ebw_space_type;

  // bus cycle sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GAP = 5'h02,
    ST_START = 5'h04,
    ST_STROBE = 5'h08,
    ST_TRAIL = 5'h10
  } ebw_state_type;
endpackage
